/* logic/adc_ctrl_pkg.sv */
// shared constants and types for the converter control block
package adc_ctrl_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [15:0] IDX_SUPPLY   = 16'hff01;
    localparam logic [15:0] IDX_CONTROL  = 16'hffd0;
    localparam logic [15:0] IDX_PINS     = 16'hffd1;
    localparam logic [15:0] IDX_RES_LO   = 16'hffd2;
    localparam logic [15:0] IDX_RES_HI   = 16'hffd3;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hffe7;
    localparam logic [15:0] IDX_IRQ_FLAG = 16'hfff7;

    // field positions
    localparam int CTRL_CHAN_LSB  = 0;
    localparam int CTRL_CLK_BIT   = 2;
    localparam int CTRL_START_BIT = 3;
    localparam int SUPPLY_BIT     = 3;
    localparam int IRQ_BIT        = 0;

    // reset values
    localparam logic [3:0]  PINS_RESET   = 4'h0;
    localparam logic [1:0]  CHAN_RESET   = 2'h0;
    localparam logic        CLKSEL_RESET = 1'b0;
    localparam logic [11:0] IRQ_VECTOR   = 12'h10e;

    // timing: a conversion is 21 converter clocks, 13 of them sampling
    localparam int RESULT_BITS       = 8;
    localparam int CONV_TICKS        = 21;
    localparam int SAMPLE_TICKS      = CONV_TICKS - RESULT_BITS;
    localparam int CLK_PERIOD_NS     = 40;
    localparam int CONV_TIME_FAST_NS = 10500;
    localparam int CONV_TIME_SLOW_NS = 641000;
    localparam int TICK_FAST_CYCLES  =
        (CONV_TIME_FAST_NS + CONV_TICKS * CLK_PERIOD_NS - 1)
        / (CONV_TICKS * CLK_PERIOD_NS);
    localparam int TICK_SLOW_CYCLES  =
        (CONV_TIME_SLOW_NS + CONV_TICKS * CLK_PERIOD_NS - 1)
        / (CONV_TICKS * CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b11
    } conv_state_t;

    typedef struct packed {
        logic        ready;
        logic        wr_pend;
        logic [15:0] ad_idx;
        logic [31:0] rdata;
        logic [3:0]  pin_sel;
        logic        clk_sel;
        logic [1:0]  chan;
        logic        supply_sel;
        logic        irq_mask;
        logic        irq_flag;
        logic        irq;
        logic [11:0] vector;
        conv_state_t state;
        logic        busy;
        logic        sample;
        logic [9:0]  tick_cnt;
        logic [4:0]  step_cnt;
        logic [2:0]  bit_idx;
        logic [7:0]  trial;
        logic [7:0]  result;
        logic        comp_s1;
        logic        comp_s2;
    } ctrl_state_t;

endpackage : adc_ctrl_pkg

/* logic/adc_control_regs.sv */
// register file and successive-approximation sequencer of the converter
//
// Operation
// - set pin select bit makes matching port pin an analog input; reset 0.
// - clock select 1 picks high-speed oscillator, 0 low-speed; reset 0.
// - two-bit channel field picks input 0..3; readable, writable, reset 0.
// - writing start 1 converts selected channel, result stored at the end.
// - writing start 0 does nothing; start reads back as 0; reset 0.
// - read-only 8-bit result, low nibble lower address, high nibble upper.
// - result register is not reset; undefined before first conversion.
// - interrupt mask 1 enables request, 0 masks it; readable, reset 0.
// - completion flag set when conversion finishes; readable; reset 0.
// - flag is set on every completion regardless of the mask.
// - writing 1 to the flag clears it; writing 0 leaves it.
// - channel not enabled as analog input gives an invalid result.
// - supply select bit is stored and read back, no effect; reset 0.
// - start begins sampling at once, for 13 ticks, then eight approximation steps.
// - interrupt request only when flag set and mask is 1.
// - completion interrupt carries its own fixed vector address.
`timescale 1ns/1ps

module adc_control_regs
    import adc_ctrl_pkg::*;
#(
    parameter logic [9:0] TICK_FAST = 10'(TICK_FAST_CYCLES),
    parameter logic [9:0] TICK_SLOW = 10'(TICK_SLOW_CYCLES)
) (
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RESETN_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // analog front end
    input  wire logic        COMP_I,
    output logic      [3:0]  ANALOG_PIN_SEL_O,
    output logic             CONV_CLK_SEL_O,
    output logic      [1:0]  CHANNEL_O,
    output logic             SUPPLY_SEL_O,
    output logic             SAMPLE_O,
    output logic      [7:0]  DAC_CODE_O,
    output logic             BUSY_O,
    // cpu interrupt
    output logic             IRQ_O,
    output logic      [11:0] IRQ_VECTOR_O
);

    ctrl_state_t r;
    ctrl_state_t n;

    // bus decode
    logic        addr_phase;
    logic [15:0] addr_idx;
    logic        rd_req;
    logic        wr_supply;
    logic        wr_ctrl;
    logic        wr_pins;
    logic        wr_mask;
    logic        wr_flag;
    logic        start_req;
    logic        flag_clr;

    // sequencer
    logic        done;
    logic        tick_end;
    logic        last_sample;
    logic        last_bit;
    logic [9:0]  tick_len;
    logic [2:0]  next_idx;
    logic [7:0]  trial_step;

    // analog routing
    logic [3:0]  chan_onehot;
    logic [3:0]  chan_route;
    logic        route_ok;
    logic        comp_bit;

    // build the read word from the state that will hold after this edge,
    // so a read right behind a write sees the written value
    function automatic logic [31:0] read_word(input ctrl_state_t s,
                                              input logic [15:0] idx);
        logic [31:0] w;

        w = 32'h0000_0000;
        case (idx)
            IDX_SUPPLY: begin
                w[SUPPLY_BIT] = s.supply_sel;
            end
            IDX_CONTROL: begin
                // the start bit is write-only and always reads as zero
                w[CTRL_CHAN_LSB +: 2] = s.chan;
                w[CTRL_CLK_BIT]       = s.clk_sel;
                w[CTRL_START_BIT]     = 1'b0;
            end
            IDX_PINS: begin
                w[3:0] = s.pin_sel;
            end
            IDX_RES_LO: begin
                // halves are not latched together: read them while idle
                w[3:0] = s.result[3:0];
            end
            IDX_RES_HI: begin
                w[3:0] = s.result[7:4];
            end
            IDX_IRQ_MASK: begin
                w[IRQ_BIT] = s.irq_mask;
            end
            IDX_IRQ_FLAG: begin
                w[IRQ_BIT] = s.irq_flag;
            end
            default: begin
                // unmapped indices read as zero and still answer okay
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction : read_word

    // a pin reaches the comparator only when it is the selected channel
    // and is enabled as an analog input
    for (genvar p = 0; p < 4; p++) begin : g_route
        assign chan_onehot[p] = (r.chan == 2'(p));
        assign chan_route[p]  = chan_onehot[p] & r.pin_sel[p];
    end
    assign route_ok = |chan_route;

    // disabled or unselected pin is not routed, so the comparator reads low
    assign comp_bit = r.comp_s2 & route_ok;

    // converter clock period counted in bus clocks; the selection is read
    // live, so changing it mid-conversion distorts the step timing
    // a tick shorter than four cycles outruns the comparator's two-stage
    // synchroniser and the trial-to-compare delay, and bits are lost
    assign tick_len    = r.clk_sel ? TICK_FAST : TICK_SLOW;
    assign tick_end    = (r.tick_cnt == tick_len - 10'd1);
    assign last_sample = (r.step_cnt == 5'(SAMPLE_TICKS - 1));
    assign last_bit    = (r.bit_idx == 3'd0);
    assign next_idx    = r.bit_idx - 3'd1;

    // word index of the access; address bits outside it are ignored
    assign addr_idx = HADDR_I[17:2];

    // per-bit trial update: the bit under test takes the comparator and
    // the bit below it becomes the next trial; the rest hold
    for (genvar b = 0; b < RESULT_BITS; b++) begin : g_trial
        assign trial_step[b] = (3'(b) == r.bit_idx) ? comp_bit
                             : ((3'(b) == next_idx) && !last_bit) ? 1'b1
                             : r.trial[b];
    end

    always_comb begin
        n    = r;
        done = 1'b0;

        // bus decode; only whole-word accesses are expected, size unused
        addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
        rd_req     = addr_phase & ~HWRITE_I;
        wr_supply  = r.wr_pend && (r.ad_idx == IDX_SUPPLY);
        wr_ctrl    = r.wr_pend && (r.ad_idx == IDX_CONTROL);
        wr_pins    = r.wr_pend && (r.ad_idx == IDX_PINS);
        wr_mask    = r.wr_pend && (r.ad_idx == IDX_IRQ_MASK);
        wr_flag    = r.wr_pend && (r.ad_idx == IDX_IRQ_FLAG);
        // a start write is honoured only from idle, see the sequencer
        start_req  = wr_ctrl && HWDATA_I[CTRL_START_BIT];
        flag_clr   = wr_flag && HWDATA_I[IRQ_BIT];

        // write data is taken in the data phase; the result nibbles and
        // unmapped indices have no write path at all
        if (wr_supply) begin
            n.supply_sel = HWDATA_I[SUPPLY_BIT];
        end

        if (wr_ctrl) begin
            n.chan    = HWDATA_I[CTRL_CHAN_LSB +: 2];
            n.clk_sel = HWDATA_I[CTRL_CLK_BIT];
        end

        if (wr_pins) begin
            n.pin_sel = HWDATA_I[3:0];
        end

        if (wr_mask) begin
            n.irq_mask = HWDATA_I[IRQ_BIT];
        end

        // comparator arrives from the analog side, two stages first
        n.comp_s1 = COMP_I;
        n.comp_s2 = r.comp_s1;

        // sample for a fixed number of ticks, then approximate bit by bit
        case (r.state)
            ST_IDLE: begin
                // a start write outside idle falls through untouched
                if (start_req) begin
                    n.state    = ST_SAMPLE;
                    n.busy     = 1'b1;
                    n.sample   = 1'b1;
                    n.tick_cnt = 10'd0;
                    n.step_cnt = 5'd0;
                end
            end

            ST_SAMPLE: begin
                // count converter ticks while the input is held
                if (tick_end) begin
                    n.tick_cnt = 10'd0;
                    n.step_cnt = r.step_cnt + 5'd1;
                end else begin
                    n.tick_cnt = r.tick_cnt + 10'd1;
                end

                if (tick_end && last_sample) begin
                    // hold ends; the first trial is the top bit alone
                    n.state   = ST_CONVERT;
                    n.sample  = 1'b0;
                    n.bit_idx = 3'(RESULT_BITS - 1);
                    n.trial   = 8'h80;
                end
            end

            ST_CONVERT: begin
                // one result bit per converter tick, top bit first
                if (tick_end) begin
                    n.tick_cnt = 10'd0;
                    n.trial    = trial_step;
                    n.bit_idx  = next_idx;
                end else begin
                    n.tick_cnt = r.tick_cnt + 10'd1;
                end

                if (tick_end && last_bit) begin
                    n.result  = trial_step;
                    n.state   = ST_IDLE;
                    n.busy    = 1'b0;
                    n.bit_idx = 3'd0;
                    n.trial   = 8'h00;
                    done      = 1'b1;
                end
            end

            default: begin
                // an illegal state code drops back to a clean idle
                n.state    = ST_IDLE;
                n.busy     = 1'b0;
                n.sample   = 1'b0;
                n.tick_cnt = 10'd0;
                n.step_cnt = 5'd0;
                n.trial    = 8'h00;
            end
        endcase

        // completion sets the flag even when a clear lands in the same
        // cycle, so a finished conversion is never lost
        if (done) begin
            n.irq_flag = 1'b1;
        end else if (flag_clr) begin
            n.irq_flag = 1'b0;
        end
        // the request follows flag and mask as they stand after this edge
        n.irq = n.irq_flag & n.irq_mask;

        // bus answer: never a wait state, read data only in the data phase
        n.ready   = 1'b1;
        n.wr_pend = addr_phase & HWRITE_I;
        n.ad_idx  = addr_idx;
        n.rdata   = rd_req ? read_word(n, addr_idx) : 32'h0000_0000;
    end

    // the result is left out of reset on purpose; every other field of the
    // state clears, and the vector is loaded with its fixed value
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            // bus answer
            r.ready      <= 1'b0;
            r.wr_pend    <= 1'b0;
            r.ad_idx     <= 16'h0000;
            r.rdata      <= 32'h0000_0000;

            // software-visible settings
            r.pin_sel    <= PINS_RESET;
            r.clk_sel    <= CLKSEL_RESET;
            r.chan       <= CHAN_RESET;
            r.supply_sel <= 1'b0;

            // interrupt
            r.irq_mask   <= 1'b0;
            r.irq_flag   <= 1'b0;
            r.irq        <= 1'b0;
            r.vector     <= IRQ_VECTOR;

            // sequencer
            r.state      <= ST_IDLE;
            r.busy       <= 1'b0;
            r.sample     <= 1'b0;
            r.tick_cnt   <= 10'd0;
            r.step_cnt   <= 5'd0;
            r.bit_idx    <= 3'd0;
            r.trial      <= 8'h00;

            // comparator synchroniser
            r.comp_s1    <= 1'b0;
            r.comp_s2    <= 1'b0;
            // result deliberately keeps its content through reset
        end else begin
            r <= n;
        end
    end

    // every output except HRESP_O comes straight from the state register
    // bus answer; the response is always okay
    assign HRDATA_O         = r.rdata;
    assign HREADYOUT_O      = r.ready;
    assign HRESP_O          = 1'b0;

    // settings copied out to the analog side
    assign ANALOG_PIN_SEL_O = r.pin_sel;
    assign CONV_CLK_SEL_O   = r.clk_sel;
    assign CHANNEL_O        = r.chan;
    assign SUPPLY_SEL_O     = r.supply_sel;

    // converter sequencing
    assign SAMPLE_O         = r.sample;
    assign DAC_CODE_O       = r.trial;
    assign BUSY_O           = r.busy;

    // interrupt
    assign IRQ_O            = r.irq;
    assign IRQ_VECTOR_O     = r.vector;

endmodule : adc_control_regs

/* testbench/adc_control_regs_chk.sv */
// port-level assertions for the converter control block
`timescale 1ns/1ps
module adc_control_regs_chk
    import adc_ctrl_pkg::*;
#(
    parameter logic [9:0] TICK_FAST = 10'(TICK_FAST_CYCLES),
    parameter logic [9:0] TICK_SLOW = 10'(TICK_SLOW_CYCLES)
) (
    // clock and reset
    input wire logic        CLOCK_I,
    input wire logic        RESETN_I,
    // bus
    input wire logic        HSEL_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    // converter and interrupt
    input wire logic        SAMPLE_O,
    input wire logic [7:0]  DAC_CODE_O,
    input wire logic        BUSY_O,
    input wire logic        IRQ_O,
    input wire logic [11:0] IRQ_VECTOR_O
);
    logic [15:0] busy_cnt;
    logic        rd_take;
    assign rd_take = HSEL_I & HTRANS_I[1] & HREADY_I & ~HWRITE_I;
    // counts busy cycles so a restart would show as a longer run
    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) busy_cnt <= 16'h0;
        else busy_cnt <= BUSY_O ? busy_cnt + 16'h1 : 16'h0;
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    a_vector_fixed: assert property (IRQ_VECTOR_O == 12'h10e)
        else $error("vector wrong");
    a_conv_length: assert property ($fell(BUSY_O) |->
        busy_cnt == 16'(CONV_TICKS * TICK_FAST)
        || busy_cnt == 16'(CONV_TICKS * TICK_SLOW)) else $error("length");
    a_sample_first: assert property ($rose(BUSY_O) |-> SAMPLE_O)
        else $error("no sample at start");
    a_sample_hold: assert property ($rose(SAMPLE_O) |-> SAMPLE_O[*8])
        else $error("sample too short");
    a_msb_trial: assert property ($fell(SAMPLE_O) |->
        BUSY_O && DAC_CODE_O == 8'h80) else $error("first trial");
    a_sample_busy: assert property (SAMPLE_O |-> BUSY_O)
        else $error("sample while idle");
    a_irq_done: assert property ($rose(IRQ_O) |-> !BUSY_O)
        else $error("irq while busy");
    a_rdata_idle: assert property (!$past(rd_take) |-> HRDATA_O == 32'h0)
        else $error("stray read data");
    a_rdata_nibble: assert property (HRDATA_O[31:4] == 28'h0)
        else $error("upper bits set");
    a_bus_ready: assert property ($past(RESETN_I) |-> HREADYOUT_O
        && !HRESP_O) else $error("bus stalled");
    cover property ($fell(BUSY_O));
    cover property ($rose(IRQ_O));
    cover property ($fell(SAMPLE_O));
endmodule : adc_control_regs_chk
bind adc_control_regs adc_control_regs_chk #(.TICK_FAST(TICK_FAST),
    .TICK_SLOW(TICK_SLOW)) u_adc_control_regs_chk (.CLOCK_I(CLOCK_I),
    .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SAMPLE_O(SAMPLE_O),
    .DAC_CODE_O(DAC_CODE_O), .BUSY_O(BUSY_O), .IRQ_O(IRQ_O),
    .IRQ_VECTOR_O(IRQ_VECTOR_O));

/* testbench/adc_control_regs_bench.sv */
// randomised register and conversion bench for the converter control block
`timescale 1ns/1ps
module adc_control_regs_bench;
    import adc_ctrl_pkg::*;
    // tick of 4 leaves room for the two-flop comparator sync
    localparam logic [9:0] TF = 10'h4;
    localparam logic [9:0] TS = 10'h6;
    logic        clk, rst_n, hsel, hwrite, comp, ready, resp;
    logic        clksel, supply, sample, busy, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, rv;
    logic [1:0]  htrans, chan, cv;
    logic [2:0]  hsize;
    logic [3:0]  pins, pv;
    logic [7:0]  dac, vin;
    logic [11:0] vec;
    int          error_cnt, num_checks, n, seed;
    adc_control_regs #(.TICK_FAST(TF), .TICK_SLOW(TS)) u_adc_control_regs (
        .CLOCK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
        .HWDATA_I(hwdata), .HREADY_I(ready), .HRDATA_O(hrdata),
        .HREADYOUT_O(ready), .HRESP_O(resp), .COMP_I(comp),
        .ANALOG_PIN_SEL_O(pins), .CONV_CLK_SEL_O(clksel), .CHANNEL_O(chan),
        .SUPPLY_SEL_O(supply), .SAMPLE_O(sample), .DAC_CODE_O(dac),
        .BUSY_O(busy), .IRQ_O(irq), .IRQ_VECTOR_O(vec));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ideal comparator against the trial code
    always @(posedge clk) comp <= (vin >= dac);
    task end_of_test;
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'b00};
        do @(posedge clk); while (ready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (ready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task rdc(input logic [15:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task conv(input logic [3:0] p, input logic [1:0] ch, input logic ck,
              input logic m);
        logic [7:0] exp;
        exp = p[ch] ? vin : 8'h00;
        xfer(1'b1, IDX_PINS, {28'h0, p});
        xfer(1'b1, IDX_IRQ_MASK, {31'h0, m});
        xfer(1'b1, IDX_CONTROL, {28'h0, 1'b1, ck, ch});
        xfer(1'b1, IDX_CONTROL, {28'h0, 1'b1, ck, ch});
        chk(busy, 1'b1);
        n = 2;
        while (busy === 1'b1 && n < 9999) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n), 32'(21 * (ck ? TF : TS) + 1));
        chk(irq, m);
        xfer(1'b1, IDX_RES_LO, {28'h0, ~exp[3:0]});
        rdc(IDX_RES_LO, {28'h0, exp[3:0]});
        rdc(IDX_RES_HI, {28'h0, exp[7:4]});
        rdc(IDX_IRQ_FLAG, 32'h1);
        xfer(1'b1, IDX_IRQ_FLAG, 32'h0);
        rdc(IDX_IRQ_FLAG, 32'h1);
        xfer(1'b1, IDX_IRQ_FLAG, 32'h1);
        rdc(IDX_IRQ_FLAG, 32'h0);
        chk(irq, 1'b0);
    endtask : conv
    initial begin
        seed = 32'h7d38;
        {rst_n, hsel, hwrite, comp, vin} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(vec, 12'h10e);
        rdc(IDX_CONTROL, 32'h0);
        rdc(IDX_PINS, 32'h0);
        rdc(IDX_SUPPLY, 32'h0);
        rdc(IDX_IRQ_MASK, 32'h0);
        rdc(IDX_IRQ_FLAG, 32'h0);
        rdc(16'h0010, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rv = $random(seed);
            pv = (i == 0) ? 4'h8 : rv[3:0];
            cv = (i == 0) ? 2'h0 : rv[5:4];
            vin <= (i == 1) ? 8'hff : (i == 2) ? 8'h00 : rv[15:8];
            xfer(1'b1, IDX_CONTROL, {29'h0, i[0], cv});
            rdc(IDX_CONTROL, {29'h0, i[0], cv});
            chk({busy, clksel, chan}, {1'b0, i[0], cv});
            conv(pv, cv, i[0], i[1]);
            rdc(IDX_PINS, {28'h0, pv});
            chk(pins, pv);
        end
        xfer(1'b1, IDX_SUPPLY, 32'hf);
        rdc(IDX_SUPPLY, 32'h8);
        chk(supply, 1'b1);
        xfer(1'b1, IDX_IRQ_MASK, 32'h1);
        rdc(IDX_IRQ_MASK, 32'h1);
        end_of_test();
    end
    initial begin
        #400000;
        error_cnt++;
        end_of_test();
    end
endmodule : adc_control_regs_bench
